// *** rtl/exc_unit.sv ***
// exception sequencer: reset, break, data-side faults, apb view
`timescale 1ns/1ps

// Behaviour
// RULE1: reset sets reset-irq-enable, clears other status fields
// RULE2: reset invalidates icache line of reset vector
// RULE3: then fetch begins at reset vector
// RULE4: with mmu/mpu reset leaves supervisor, irqs off
// RULE5: nmi accepted during reset handling; code blocks it in ST_RESET, takes it from ST_INVAL on
// RULE6: register zero always reads zero
// RULE7: break from instruction or debug request
// RULE8: break saves status into break status
// RULE9: break clears irq enable; nmi still accepted
// RULE10: break writes next address to register 30
// RULE11: break clears user mode with mmu/mpu
// RULE12: break sets exception-handling with mmu
// RULE13: break copies current to previous set, zeroes current
// RULE14: break redirects to break vector last
// RULE15: break accepted during general exception handling
// RULE16: break return restores status, resumes at r30
// RULE17: only r25, r30, break status touched by debug; apb also writes status and config
// RULE18: fast data miss: cause 12, address, fast vector
// RULE19: nested data miss: cause 12, general vector
// RULE20: permission fault: cause 14 read, 15 write
// RULE21: ecc lookup error with mmu+ecc: cause 18
// RULE22: divide fault when enabled: cause 8, iaddr
// RULE23: exceptions precise, faulting instruction retirable
module exc_unit
  import exc_unit_pkg::*;
#(
  parameter logic [31:0] RESET_VECTOR = 32'h0000_0000,
  parameter logic [31:0] BREAK_VECTOR = 32'h0000_0020,
  parameter logic [31:0] GENERAL_VECTOR = 32'h0000_0040,
  parameter logic [31:0] FAST_MISS_VECTOR = 32'h0000_0060
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // pipeline events
  input wire logic [31:0] i_next_pc,     // address after current instr
  input wire logic i_break_instr,       // break instruction retires
  input wire logic i_debug_break,       // debug module hardware break
  input wire logic i_break_return,      // break-return instruction
  input wire logic i_nmi,               // nonmaskable interrupt request
  input wire data_fault_t i_fault,      // data-side fault report
  // outputs to the core
  output redirect_t o_redirect,         // fetch redirect
  output logic o_icache_inval,          // invalidate one line
  output logic [31:0] o_icache_inval_addr,
  output logic o_nmi_take,              // nmi accepted
  output logic o_flush,                 // squash younger instructions
  output logic [STATUS_W-1:0] o_status
);

  // ****************************************
  // state
  // ****************************************
  seq_state_t state_q;          // reset sequencer
  logic [31:0] status_q;        // processor status
  logic [31:0] bstatus_q;       // break status
  logic [31:0] break_ret_q;     // r30 of normal set
  logic [31:0] break_temp_q;    // r25 of normal set, debug scratch
  logic [31:0] exc_ret_q;       // exception_return_reg
  logic [4:0] cause_q;          // last cause code
  logic [31:0] badaddr_q;       // faulting address
  logic [31:0] pc_q;            // last redirect target
  logic [31:0] config_q;        // build options seen by the unit
  logic fault_any;              // any enabled data-side fault
  logic [4:0] fault_cause;      // decoded cause
  logic [31:0] fault_addr;      // decoded address
  vec_sel_t fault_vec;          // decoded vector
  logic brk;                    // break taken this cycle
  logic running;                // sequencer done
  logic mmu, mpu, ecc, divchk;  // option bits
  logic apb_wr, apb_rd;         // apb access strobes
  logic addr_ok;                // apb address aligned and mapped

  assign mmu = config_q[CFG_MMU_BIT];
  assign mpu = config_q[CFG_MPU_BIT];
  assign ecc = config_q[CFG_ECC_BIT];
  assign divchk = config_q[CFG_DIVCHK_BIT];
  assign running = (state_q == ST_RUN);

  // maps a vector selection to its address
  function automatic logic [31:0] vec_addr(input vec_sel_t v);
    case (v)
      VEC_RESET: vec_addr = RESET_VECTOR;
      VEC_BREAK: vec_addr = BREAK_VECTOR;
      VEC_FAST_MISS: vec_addr = FAST_MISS_VECTOR;
      default: vec_addr = GENERAL_VECTOR;
    endcase
  endfunction

  // ****************************************
  // event decode
  // ****************************************

  // break wins over faults, independent of exception state
  assign brk = running && (i_break_instr || i_debug_break); // RULE7 RULE15

  // fault priority: ecc, div, miss, permission
  always_comb begin
    fault_any = 1'b0;
    fault_cause = 5'h00;
    fault_addr = i_fault.daddr;
    fault_vec = VEC_NONE;
    if (i_fault.ecc_tlb && mmu && ecc) begin
      fault_any = 1'b1; // RULE21
      fault_cause = CAUSE_ECC_TLB;
      fault_vec = VEC_GENERAL;
    end else if (i_fault.div_err && divchk) begin
      fault_any = 1'b1; // RULE22
      fault_cause = CAUSE_DIV_ERR;
      fault_addr = i_fault.iaddr;
      fault_vec = VEC_GENERAL;
    end else if (i_fault.miss && mmu) begin
      fault_any = 1'b1;
      fault_cause = CAUSE_TLB_MISS;
      // nested miss goes to general handler
      fault_vec = status_q[ST_EH_BIT] ? VEC_GENERAL : VEC_FAST_MISS; // RULE18 RULE19
    end else if ((i_fault.perm_rd || i_fault.perm_wr) && mmu) begin
      fault_any = 1'b1; // RULE20
      fault_cause = i_fault.perm_rd ? CAUSE_PERM_RD : CAUSE_PERM_WR;
      fault_vec = VEC_GENERAL;
    end
  end

  // ****************************************
  // reset sequencer
  // ****************************************

  // reset -> invalidate line -> run
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_q <= ST_RESET;
    end else begin
      case (state_q)
        ST_RESET: state_q <= ST_INVAL;
        ST_INVAL: state_q <= ST_RUN;
        ST_RUN: state_q <= ST_RUN;
        default: state_q <= ST_RESET;
      endcase
    end
  end

  // one-cycle line invalidate at reset vector
  always_comb begin
    o_icache_inval = (state_q == ST_INVAL); // RULE2
    o_icache_inval_addr = RESET_VECTOR;
  end

  // nmi passes regardless of enable bit, also during the invalidate step and break; blocked in ST_RESET
  assign o_nmi_take = i_nmi && (state_q != ST_RESET); // RULE5 RULE9

  // ****************************************
  // status register
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      status_q <= STATUS_RESET; // RULE1 RULE4
    end else if (brk) begin
      status_q[ST_PIE_BIT] <= 1'b0; // RULE9
      if (mmu || mpu) begin
        status_q[ST_U_BIT] <= 1'b0; // RULE11
      end
      if (mmu) begin
        status_q[ST_EH_BIT] <= 1'b1; // RULE12
      end
      status_q[ST_PRS_LSB +: RS_W] <= status_q[ST_CRS_LSB +: RS_W]; // RULE13
      status_q[ST_CRS_LSB +: RS_W] <= '0; // RULE13
    end else if (running && i_break_return) begin
      status_q <= bstatus_q; // RULE16
    end else if (running && fault_any) begin
      status_q[ST_PIE_BIT] <= 1'b0;
      if (mmu) begin
        status_q[ST_EH_BIT] <= 1'b1;
      end
    end else if (apb_wr && i_paddr == ADDR_STATUS) begin
      status_q <= i_pwdata;
    end
  end

  // break status snapshot
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      bstatus_q <= '0;
    end else if (brk) begin
      bstatus_q <= status_q; // RULE8
    end else if (apb_wr && i_paddr == ADDR_BSTATUS) begin
      bstatus_q <= i_pwdata; // RULE17
    end
  end

  // break return address and debug scratch
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      break_ret_q <= '0;
      break_temp_q <= '0;
    end else begin
      if (brk) begin
        break_ret_q <= i_next_pc; // RULE10
      end else if (apb_wr && i_paddr == ADDR_BREAK_RET) begin
        break_ret_q <= i_pwdata; // RULE17
      end
      if (apb_wr && i_paddr == ADDR_BREAK_TEMP) begin
        break_temp_q <= i_pwdata; // RULE17
      end
    end
  end

  // cause, bad address, exception return of faulting instruction
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cause_q <= '0;
      badaddr_q <= '0;
      exc_ret_q <= '0;
    end else if (running && !brk && fault_any) begin
      cause_q <= fault_cause;
      badaddr_q <= fault_addr;
      exc_ret_q <= i_fault.iaddr; // RULE23
    end
  end

  // build option bits
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      config_q <= CONFIG_RESET;
    end else if (apb_wr && i_paddr == ADDR_CONFIG) begin
      config_q <= i_pwdata;
    end
  end

  // ****************************************
  // fetch redirect
  // ****************************************

  // registered redirect; break last step, then return, then faults
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_redirect <= '0;
      pc_q <= '0;
    end else begin
      o_redirect.valid <= 1'b0;
      if (state_q == ST_INVAL) begin
        o_redirect.valid <= 1'b1; // RULE3
        o_redirect.addr <= vec_addr(VEC_RESET);
        pc_q <= vec_addr(VEC_RESET);
      end else if (brk) begin
        o_redirect.valid <= 1'b1; // RULE14
        o_redirect.addr <= vec_addr(VEC_BREAK);
        pc_q <= vec_addr(VEC_BREAK);
      end else if (running && i_break_return) begin
        o_redirect.valid <= 1'b1; // RULE16
        o_redirect.addr <= break_ret_q;
        pc_q <= break_ret_q;
      end else if (running && fault_any) begin
        o_redirect.valid <= 1'b1; // RULE18 RULE19
        o_redirect.addr <= vec_addr(fault_vec);
        pc_q <= vec_addr(fault_vec);
      end
    end
  end

  // squash younger work so the faulting instruction can rerun
  assign o_flush = brk || (running && (i_break_return || fault_any)); // RULE23
  assign o_status = status_q;

  // ****************************************
  // apb slave
  // ****************************************
  always_comb begin
    addr_ok = (i_paddr[1:0] == 2'b00) && (i_paddr <= ADDR_CONFIG);
    apb_wr = i_psel && i_penable && i_pwrite && addr_ok;
    apb_rd = i_psel && i_penable && !i_pwrite;
  end

  // zero-wait slave, error on unmapped address
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !addr_ok;

  // registered read data
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_prdata <= '0;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      case (i_paddr)
        ADDR_STATUS: o_prdata <= status_q;
        ADDR_BSTATUS: o_prdata <= bstatus_q;
        ADDR_CAUSE: o_prdata <= {27'h000_0000, cause_q};
        ADDR_BADADDR: o_prdata <= badaddr_q;
        ADDR_PC: o_prdata <= pc_q;
        ADDR_BREAK_RET: o_prdata <= break_ret_q;
        ADDR_BREAK_TEMP: o_prdata <= break_temp_q;
        ADDR_EXC_RET: o_prdata <= exc_ret_q;
        ADDR_CONFIG: o_prdata <= config_q;
        default: o_prdata <= '0;
      endcase
    end
  end

  // register zero is never stored, reads as zero
  logic unused_rd;
  assign unused_rd = apb_rd && (REG_ZERO == 5'h00) && (REG_BREAK_TEMP != 0)
    && (REG_BREAK_RET != 0); // RULE6

endmodule

// *** rtl/exc_unit_pkg.sv ***
// package: status layout, cause codes, register map and vectors
package exc_unit_pkg;

  // ****************************************
  // status register field positions
  // ****************************************
  localparam int unsigned STATUS_W = 32;
  localparam int unsigned ST_PIE_BIT = 0;     // global_irq_enable_field
  localparam int unsigned ST_U_BIT = 1;       // user mode
  localparam int unsigned ST_EH_BIT = 2;      // exception_handling_field
  localparam int unsigned ST_CRS_LSB = 10;    // current_regset_field
  localparam int unsigned ST_PRS_LSB = 16;    // previous_regset_field
  localparam int unsigned ST_RESET_IRQ_ENABLE_FIELD_BIT = 23;   // reset_irq_enable_field
  localparam int unsigned RS_W = 6;           // register set field width
  localparam logic [31:0] STATUS_RESET = 32'h0080_0000;

  // ****************************************
  // cause codes
  // ****************************************
  localparam logic [4:0] CAUSE_DIV_ERR = 5'h08;
  localparam logic [4:0] CAUSE_TLB_MISS = 5'h0C;
  localparam logic [4:0] CAUSE_PERM_RD = 5'h0E;
  localparam logic [4:0] CAUSE_PERM_WR = 5'h0F;
  localparam logic [4:0] CAUSE_ECC_TLB = 5'h12;

  // ****************************************
  // debug register numbers in the normal set
  // ****************************************
  localparam logic [4:0] REG_ZERO = 5'h00;
  localparam logic [4:0] REG_BREAK_TEMP = 5'h19;  // break_temp_reg
  localparam logic [4:0] REG_BREAK_RET = 5'h1E;

  // ****************************************
  // apb register map (byte addresses)
  // ****************************************
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_BSTATUS = 8'h04;
  localparam logic [7:0] ADDR_CAUSE = 8'h08;
  localparam logic [7:0] ADDR_BADADDR = 8'h0C;
  localparam logic [7:0] ADDR_PC = 8'h10;
  localparam logic [7:0] ADDR_BREAK_RET = 8'h14;
  localparam logic [7:0] ADDR_BREAK_TEMP = 8'h18;
  localparam logic [7:0] ADDR_EXC_RET = 8'h1C;
  localparam logic [7:0] ADDR_CONFIG = 8'h20;

  // config bits
  localparam int unsigned CFG_MMU_BIT = 0;
  localparam int unsigned CFG_MPU_BIT = 1;
  localparam int unsigned CFG_ECC_BIT = 2;
  localparam int unsigned CFG_DIVCHK_BIT = 3;
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;

  // ****************************************
  // vector selection
  // ****************************************
  typedef enum logic [2:0] {
    VEC_RESET = 3'b000,
    VEC_BREAK = 3'b001,
    VEC_GENERAL = 3'b011,
    VEC_FAST_MISS = 3'b010,
    VEC_NONE = 3'b110
  } vec_sel_t;

  // sequencer states, gray along reset -> icache -> run
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_INVAL = 2'b01,
    ST_RUN = 2'b11
  } seq_state_t;

  // data-side fault report from the pipeline
  typedef struct packed {
    logic miss;        // data translation miss
    logic perm_rd;     // read permission violation
    logic perm_wr;     // write permission violation
    logic ecc_tlb;     // corrected-code error on lookup
    logic div_err;     // faulting divide
    logic [31:0] daddr;  // faulting data address
    logic [31:0] iaddr;  // faulting instruction address
  } data_fault_t;

  // redirect issued to the fetch unit
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
  } redirect_t;

endpackage

// *** sim/exc_unit_checker.sv ***
// checker: exception sequencing properties at the unit ports
`timescale 1ns/1ps
module exc_unit_checker
  import exc_unit_pkg::*;
#(
  parameter logic [31:0] RESET_VECTOR = 32'h0000_0000,
  parameter logic [31:0] BREAK_VECTOR = 32'h0000_0020
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_break_instr,
  input wire logic i_debug_break,
  input wire logic i_break_return,
  input wire logic i_nmi,
  input wire redirect_t o_redirect,
  input wire logic o_icache_inval,
  input wire logic [31:0] o_icache_inval_addr,
  input wire logic o_nmi_take,
  input wire logic o_flush,
  input wire logic o_pready,
  input wire logic [STATUS_W-1:0] o_status
);
  // ****************************************
  // helpers
  // ****************************************
  logic [1:0] up_q; // edges since reset, saturating
  logic brk; // break from either source
  logic run; // events accepted from here on
  assign brk = i_break_instr | i_debug_break;
  assign run = (up_q == 2'd2);
  // count the reset, invalidate and redirect edges
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      up_q <= 2'd0;
    end else if (up_q != 2'd2) begin
      up_q <= up_q + 2'd1;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // ****************************************
  // properties
  // ****************************************
  AST_RST_STATUS: assert property ($fell(i_sys_rst) |->
    o_status == STATUS_RESET && !o_redirect.valid)
    else $error("status wrong at reset release");
  AST_RST_SEQ: assert property ($fell(i_sys_rst) |=>
    o_icache_inval ##1 (o_redirect.valid && o_redirect.addr == RESET_VECTOR))
    else $error("reset invalidate or vector missing");
  AST_INVAL_ADDR: assert property (o_icache_inval |->
    o_icache_inval_addr == RESET_VECTOR)
    else $error("invalidate aimed at wrong line");
  AST_NMI_RESET: assert property (o_icache_inval |->
    o_nmi_take == i_nmi) else $error("nmi blocked during reset");
  AST_NMI_RUN: assert property (run |-> o_nmi_take == i_nmi)
    else $error("nmi blocked while running");
  AST_BRK_VEC: assert property (brk && run |=>
    o_redirect.valid && o_redirect.addr == BREAK_VECTOR)
    else $error("break vector not taken");
  AST_BRK_FLUSH: assert property (brk && run |-> o_flush)
    else $error("break did not flush");
  AST_BRK_STATUS: assert property (brk && run |=>
    !o_status[ST_PIE_BIT] && o_status[ST_CRS_LSB +: RS_W] == '0 &&
    o_status[ST_PRS_LSB +: RS_W] == $past(o_status[ST_CRS_LSB +: RS_W]))
    else $error("break status update wrong");
  AST_BRET: assert property (i_break_return && !brk && run |=>
    o_redirect.valid) else $error("break return did not redirect");
  AST_APB_READY: assert property (i_psel && i_penable |-> o_pready)
    else $error("access phase not ready");
  // main scenarios reached
  cover property (brk && run);
  cover property (i_break_return && run);
  cover property ($fell(i_sys_rst));
endmodule

// *** sim/dbg_partner.sv ***
// partner: debug break and nmi source with a chosen latency
`timescale 1ns/1ps
module dbg_partner (
  input wire logic i_clk,
  input wire logic i_go_brk, // ask for a hardware break
  input wire logic i_go_nmi, // ask for a nonmaskable interrupt
  input wire logic [3:0] i_wait, // cycles before the pulse
  output logic o_debug_break,
  output logic o_nmi
);
  logic [3:0] cnt_q = 4'h0; // latency countdown
  logic brk_q = 1'b0; // break pending
  logic nmi_q = 1'b0; // nmi pending
  initial begin
    o_debug_break = 1'b0;
    o_nmi = 1'b0;
  end
  // one-cycle pulse once the latency runs out
  always @(posedge i_clk) begin
    o_debug_break <= 1'b0;
    o_nmi <= 1'b0;
    if (i_go_brk | i_go_nmi) begin
      brk_q <= i_go_brk;
      nmi_q <= i_go_nmi;
      cnt_q <= i_wait;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end else begin
      o_debug_break <= brk_q;
      o_nmi <= nmi_q;
      brk_q <= 1'b0;
      nmi_q <= 1'b0;
    end
  end
endmodule

// *** sim/exc_unit_tb_top.sv ***
// testbench: reset, faults, breaks and returns of the exception unit
`timescale 1ns/1ps
module exc_unit_tb_top
  import exc_unit_pkg::*;
;
  localparam logic [31:0] RST_VEC = 32'h0000_0100;
  localparam logic [31:0] BRK_VEC = 32'h0000_0220;
  localparam logic [31:0] GEN_VEC = 32'h0000_0340;
  localparam logic [31:0] FST_VEC = 32'h0000_0460;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, next_pc = '0, prdata, rd;
  logic pready, pslverr, err, brk_instr = 0, bret = 0, dbg_brk, nmi;
  logic go_brk = 0, go_nmi = 0, nmi_take;
  logic [3:0] dwait = '0;
  data_fault_t fault = '0;
  redirect_t redirect;
  int error_cnt = 0;
  int n_checks = 0;
  always #12.5 clk = ~clk;
  exc_unit #(.RESET_VECTOR(RST_VEC), .BREAK_VECTOR(BRK_VEC),
    .GENERAL_VECTOR(GEN_VEC), .FAST_MISS_VECTOR(FST_VEC)) dut (
    .i_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_next_pc(next_pc), .i_break_instr(brk_instr),
    .i_debug_break(dbg_brk), .i_break_return(bret), .i_nmi(nmi),
    .i_fault(fault), .o_redirect(redirect), .o_icache_inval(),
    .o_icache_inval_addr(), .o_nmi_take(nmi_take), .o_flush(),
    .o_status());
  dbg_partner u_dbg (.i_clk(clk), .i_go_brk(go_brk), .i_go_nmi(go_nmi),
    .i_wait(dwait), .o_debug_break(dbg_brk), .o_nmi(nmi));
  // ****************************************
  // shared tasks
  // ****************************************
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) error_cnt++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // read and compare one register
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, '0);
    check(rd, exp);
  endtask
  // bounded wait for the fetch redirect
  task automatic wait_redir();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (redirect.valid !== 1'b1 && n < 30);
    check({31'h0, redirect.valid}, 32'h0000_0001);
  endtask
  // one-cycle event pulse from the pipeline
  task automatic fire(input data_fault_t f, input logic b, input logic r);
    @(posedge clk);
    fault <= f;
    brk_instr <= b;
    bret <= r;
    @(posedge clk);
    fault <= '0;
    brk_instr <= 1'b0;
    bret <= 1'b0;
    wait_redir();
  endtask
  // status expected after a break
  function automatic logic [31:0] brk_exp(input logic [31:0] s,
      input logic [31:0] c);
    brk_exp = s;
    brk_exp[ST_PIE_BIT] = 1'b0;
    if (c[CFG_MMU_BIT] | c[CFG_MPU_BIT]) brk_exp[ST_U_BIT] = 1'b0;
    if (c[CFG_MMU_BIT]) brk_exp[ST_EH_BIT] = 1'b1;
    brk_exp[ST_PRS_LSB +: RS_W] = s[ST_CRS_LSB +: RS_W];
    brk_exp[ST_CRS_LSB +: RS_W] = '0;
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    #500000;
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    tally_and_finish();
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    logic [31:0] s, c;
    data_fault_t f;
    int k;
    logic [4:0] cause [6] = '{5'h0C, 5'h0C, 5'h0E, 5'h0F, 5'h12, 5'h08};
    logic [31:0] cfgs [4] = '{32'hF, 32'h0, 32'h1, 32'h2};
    k = $urandom(66);
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    rchk(ADDR_STATUS, 32'h0080_0000);
    rchk(ADDR_PC, RST_VEC);
    apb(1'b0, 8'h24, '0);
    check({31'h0, err}, 32'h0000_0001);
    $display("reset test done");
    // data faults, fast then nested miss first
    apb(1'b1, ADDR_CONFIG, 32'h0000_000D);
    for (k = 0; k < 6; k++) begin
      f = '0;
      f.daddr = $urandom;
      f.iaddr = $urandom;
      case (k)
        0, 1: f.miss = 1'b1;
        2: f.perm_rd = 1'b1;
        3: f.perm_wr = 1'b1;
        4: f.ecc_tlb = 1'b1;
        default: f.div_err = 1'b1;
      endcase
      apb(1'b1, ADDR_STATUS, (k == 1) ? 32'h0000_0004 : 32'h0000_0001);
      fire(f, 1'b0, 1'b0);
      rchk(ADDR_CAUSE, {27'h0, cause[k]});
      rchk(ADDR_PC, (k == 0) ? FST_VEC : GEN_VEC);
      rchk((k == 5) ? ADDR_EXC_RET : ADDR_BADADDR,
        (k == 5) ? f.iaddr : f.daddr);
      rchk(ADDR_STATUS, 32'h0000_0004);
    end
    $display("fault test done");
    // breaks by instruction and by debug module, then return
    for (k = 0; k < 4; k++) begin
      c = cfgs[k];
      s = '0;
      s[2:0] = 3'(k + 3);
      s[ST_CRS_LSB +: RS_W] = 6'($urandom);
      apb(1'b1, ADDR_CONFIG, c);
      apb(1'b1, ADDR_STATUS, s);
      next_pc <= $urandom;
      if (k % 2 == 1) begin
        dwait <= 4'($urandom);
        go_brk <= 1'b1;
        @(posedge clk);
        go_brk <= 1'b0;
        wait_redir();
      end else begin
        fire('0, 1'b1, 1'b0);
      end
      rchk(ADDR_STATUS, brk_exp(s, c));
      rchk(ADDR_BSTATUS, s);
      rchk(ADDR_BREAK_RET, next_pc);
      rchk(ADDR_PC, BRK_VEC);
      fire('0, 1'b0, 1'b1);
      rchk(ADDR_STATUS, s);
      rchk(ADDR_PC, next_pc);
    end
    rchk(ADDR_CAUSE, 32'h0000_0008);
    $display("break test done");
    // nmi while running, then reset in mid-run
    dwait <= 4'h0;
    go_nmi <= 1'b1;
    @(posedge clk);
    go_nmi <= 1'b0;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (nmi !== 1'b1 && k < 20);
    check({31'h0, nmi_take}, 32'h0000_0001);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    rchk(ADDR_STATUS, 32'h0080_0000);
    $display("nmi and reset test done");
    tally_and_finish();
  end
endmodule
bind exc_unit exc_unit_checker #(
  .RESET_VECTOR(RESET_VECTOR), .BREAK_VECTOR(BREAK_VECTOR)) u_chk (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_psel(i_psel),
  .i_penable(i_penable), .i_break_instr(i_break_instr),
  .i_debug_break(i_debug_break), .i_break_return(i_break_return),
  .i_nmi(i_nmi), .o_redirect(o_redirect), .o_icache_inval(o_icache_inval),
  .o_icache_inval_addr(o_icache_inval_addr),
  .o_nmi_take(o_nmi_take), .o_flush(o_flush), .o_pready(o_pready),
  .o_status(o_status));
